// >>> rtl/qawsj_defs.svh
// constants for the question-and-answer watchdog sequence judge
`ifndef QAWSJ_DEFS_SVH
`define QAWSJ_DEFS_SVH

// index of the first answer byte expected in a sequence
`define QAWSJ_IDX_FIRST 2'h3
// index of the last answer byte expected in a sequence
`define QAWSJ_IDX_LAST 2'h0
// answers the first window must hold for a good sequence
`define QAWSJ_W1_NEEDED 3'h3
// failure tally limits
`define QAWSJ_TALLY_MAX 3'h7
`define QAWSJ_TALLY_MIN 3'h0
// tally value after reset
`define QAWSJ_TALLY_RESET 3'h0

`endif

// >>> rtl/qawsj_pkg.sv
// types for the question-and-answer watchdog sequence judge
package qawsj_pkg;

  // which response window the sequence is in
  typedef enum logic {
    ST_WIN1,
    ST_WIN2
  } qawsj_state_type;

endpackage

// >>> rtl/qawsj_window_timer.sv
// response window timer: first window, then second window
`timescale 1ns/1ns
module qawsj_window_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic restart,
  // window lengths in clock cycles, at least one
  input wire logic [CNT_W-1:0] win1_len,
  input wire logic [CNT_W-1:0] win2_len,
  // one-cycle pulses at window ends
  output logic win1_end,
  output logic win2_end
);

  logic [CNT_W-1:0] count; // cycles left in the current window
  logic in_win2; // low in first window, high in second
  logic expired; // second window has run out, waiting for restart
  logic armed; // a first window has been loaded since reset

  // count down each window; stop after the second until restarted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      in_win2 <= 1'b0;
      expired <= 1'b0;
      win1_end <= 1'b0;
      win2_end <= 1'b0;
      armed <= 1'b0;
    end else if (!enable || restart || !armed) begin
      // fresh sequence starts with the first window, also right after reset
      count <= win1_len;
      armed <= 1'b1;
      in_win2 <= 1'b0;
      expired <= 1'b0;
      win1_end <= 1'b0;
      win2_end <= 1'b0;
    end else if (expired) begin
      // hold quietly until the judge restarts us
      win1_end <= 1'b0;
      win2_end <= 1'b0;
    end else if (count <= CNT_W'(1)) begin
      // window boundary reached
      win1_end <= !in_win2;
      win2_end <= in_win2;
      expired <= in_win2;
      in_win2 <= 1'b1;
      count <= win2_len;
    end else begin
      count <= count - CNT_W'(1);
      win1_end <= 1'b0;
      win2_end <= 1'b0;
    end
  end

endmodule // qawsj_window_timer

// >>> rtl/qawsj_judge.sv
// judge of one question-and-answer watchdog sequence
`timescale 1ns/1ns
`include "qawsj_defs.svh"
module qawsj_judge #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic wd_enable,
  input wire logic [CNT_W-1:0] win1_len,
  input wire logic [CNT_W-1:0] win2_len,
  // answer write from the register logic, same clock
  input wire logic answer_write,
  input wire logic [7:0] answer_byte_port,
  input wire logic [7:0] expected_answer,
  // write-one-to-clear strobes for the status flags
  input wire logic clear_wrong_answer,
  input wire logic clear_premature_answer,
  input wire logic clear_sequence_error,
  input wire logic clear_timeout,
  // status flags
  output logic wrong_answer_flag,
  output logic premature_answer_flag,
  output logic sequence_error_flag,
  output logic timeout_flag,
  output logic failed_sequence_indicator,
  // sequence state
  output logic [1:0] pending_answer_index,
  output logic window2_active,
  output logic [2:0] failure_tally,
  output logic sequence_end,
  output logic question_advance
);

  qawsj_pkg::qawsj_state_type state; // current response window
  logic [2:0] w1_count; // answers taken in the first window
  logic seq_bad; // sequence already failed
  logic win1_end; // timer pulse, first window over
  logic win2_end; // timer pulse, second window over
  logic ans_ok; // written byte matches reference
  logic is_last; // this write is the fourth answer
  logic wr_w1; // answer in first window
  logic wr_w2; // answer in second window
  logic wrong_now; // incorrect byte this cycle
  logic early_now; // fourth answer in first window
  logic short_now; // first window closes with too few answers
  logic timeout_now; // second window closes before fourth answer
  logic end_now; // sequence ends this cycle
  logic fail_now; // sequence ending this cycle has failed
  logic [2:0] w1_total; // first window answers including this write

  // window timing; restarted whenever a sequence ends
  qawsj_window_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(wd_enable),
    .restart(end_now),
    .win1_len(win1_len),
    .win2_len(win2_len),
    .win1_end(win1_end),
    .win2_end(win2_end)
  );

  // decode of the current answer write and window events
  always_comb begin
    ans_ok = (answer_byte_port == expected_answer);
    is_last = (pending_answer_index == `QAWSJ_IDX_LAST);
    wr_w1 = wd_enable && answer_write && (state == qawsj_pkg::ST_WIN1);
    wr_w2 = wd_enable && answer_write && (state == qawsj_pkg::ST_WIN2);
    wrong_now = (wr_w1 || wr_w2) && !ans_ok;
    w1_total = w1_count + {2'h0, wr_w1};
    early_now = wr_w1 && is_last;
    short_now = wd_enable && (state == qawsj_pkg::ST_WIN1) && win1_end && !early_now
                && (w1_total < `QAWSJ_W1_NEEDED);
    timeout_now = wd_enable && (state == qawsj_pkg::ST_WIN2) && win2_end
                  && !(wr_w2 && is_last);
    end_now = early_now || (wr_w2 && is_last) || timeout_now;
    fail_now = seq_bad || wrong_now || early_now || timeout_now;
  end

  // window state: first window, second window, back on sequence end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= qawsj_pkg::ST_WIN1;
      window2_active <= 1'b0;
    end else if (!wd_enable || end_now) begin
      // every new cycle opens with the first window
      state <= qawsj_pkg::ST_WIN1;
      window2_active <= 1'b0;
    end else begin
      case (state)
        qawsj_pkg::ST_WIN1: begin
          if (win1_end) begin
            state <= qawsj_pkg::ST_WIN2;
            window2_active <= 1'b1;
          end
        end
        qawsj_pkg::ST_WIN2: begin
          window2_active <= 1'b1;
        end
        default: begin
          state <= qawsj_pkg::ST_WIN1;
          window2_active <= 1'b0;
        end
      endcase
    end
  end

  // answer bookkeeping: index counts down, first window answers counted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_answer_index <= `QAWSJ_IDX_FIRST;
      w1_count <= 3'h0;
    end else if (!wd_enable || end_now) begin
      pending_answer_index <= `QAWSJ_IDX_FIRST;
      w1_count <= 3'h0;
    end else begin
      if (wr_w1 || wr_w2) begin
        pending_answer_index <= pending_answer_index - 2'h1;
      end
      if (wr_w1) begin
        w1_count <= w1_total;
      end
    end
  end

  // sequence failure memory and the bad-event indication
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_bad <= 1'b0;
      failed_sequence_indicator <= 1'b0;
    end else if (!wd_enable) begin
      seq_bad <= 1'b0;
      failed_sequence_indicator <= 1'b0;
    end else if (end_now) begin
      // shown for the ending cycle, cleared once the next one starts
      seq_bad <= 1'b0;
      failed_sequence_indicator <= fail_now;
    end else if (wrong_now || short_now) begin
      seq_bad <= 1'b1;
      failed_sequence_indicator <= 1'b1;
    end else if (sequence_end) begin
      failed_sequence_indicator <= seq_bad;
    end
  end

  // sticky status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrong_answer_flag <= 1'b0;
      premature_answer_flag <= 1'b0;
      sequence_error_flag <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      wrong_answer_flag <= wrong_now || (wrong_answer_flag && !clear_wrong_answer);
      premature_answer_flag <= early_now
                               || (premature_answer_flag && !clear_premature_answer);
      sequence_error_flag <= short_now
                             || (sequence_error_flag && !clear_sequence_error);
      timeout_flag <= timeout_now || (timeout_flag && !clear_timeout);
    end
  end

  // failure tally and question advance at the end of each sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      failure_tally <= `QAWSJ_TALLY_RESET;
      sequence_end <= 1'b0;
      question_advance <= 1'b0;
    end else begin
      sequence_end <= end_now;
      question_advance <= end_now && !fail_now;
      if (end_now && fail_now && failure_tally != `QAWSJ_TALLY_MAX) begin
        failure_tally <= failure_tally + 3'h1;
      end else if (end_now && !fail_now && failure_tally != `QAWSJ_TALLY_MIN) begin
        failure_tally <= failure_tally - 3'h1;
      end
    end
  end

  // checks of the sequence outcomes
  sequence s_fourth_in_w2;
    wr_w2 && is_last;
  endsequence

  sequence s_expiry;
    timeout_now;
  endsequence

  property p_no_answers;
    @(posedge ref_clk) disable iff (!rst_n)
      s_expiry ##0 (pending_answer_index == `QAWSJ_IDX_FIRST)
      |=> sequence_end && sequence_error_flag && timeout_flag;
  endproperty
  a_no_answers: assert property (p_no_answers) else $error("no-answer outcome wrong");

  property p_same_question;
    @(posedge ref_clk) disable iff (!rst_n)
      end_now && fail_now |=> sequence_end && !question_advance;
  endproperty
  a_same_question: assert property (p_same_question) else $error("failed sequence advanced");

  property p_late_correct;
    @(posedge ref_clk) disable iff (!rst_n)
      s_fourth_in_w2 ##0 ans_ok && w1_count == 3'h0 && !timeout_flag
      |=> sequence_end && sequence_error_flag && !timeout_flag ##1 !sequence_end;
  endproperty
  a_late_correct: assert property (p_late_correct) else $error("late correct answers misjudged");

  property p_fourth_restarts;
    @(posedge ref_clk) disable iff (!rst_n)
      s_fourth_in_w2 ##0 !timeout_flag
      |=> sequence_end && !timeout_flag && pending_answer_index == `QAWSJ_IDX_FIRST;
  endproperty
  a_fourth_restarts: assert property (p_fourth_restarts) else $error("fourth answer no restart");

  property p_short_timeout;
    @(posedge ref_clk) disable iff (!rst_n)
      s_expiry ##0 w1_count < `QAWSJ_W1_NEEDED
      |=> timeout_flag && sequence_error_flag && sequence_end;
  endproperty
  a_short_timeout: assert property (p_short_timeout) else $error("timeout flags missing");

  property p_wrong_then_expiry;
    @(posedge ref_clk) disable iff (!rst_n)
      s_expiry ##0 wrong_answer_flag && !clear_wrong_answer && !clear_timeout
      |=> wrong_answer_flag && timeout_flag && sequence_end;
  endproperty
  a_wrong_then_expiry: assert property (p_wrong_then_expiry) else $error("wrong flag lost");

  property p_wrong_sets;
    @(posedge ref_clk) disable iff (!rst_n)
      wrong_now |=> wrong_answer_flag && failed_sequence_indicator;
  endproperty
  a_wrong_sets: assert property (p_wrong_sets) else $error("wrong answer not flagged");

  property p_tally_up;
    @(posedge ref_clk) disable iff (!rst_n)
      end_now && fail_now && failure_tally != `QAWSJ_TALLY_MAX
      |=> failure_tally == $past(failure_tally) + 3'h1;
  endproperty
  a_tally_up: assert property (p_tally_up) else $error("tally did not rise");

  property p_good_sequence;
    @(posedge ref_clk) disable iff (!rst_n)
      end_now && !fail_now && failure_tally != `QAWSJ_TALLY_MIN
      |=> question_advance && failure_tally == $past(failure_tally) - 3'h1;
  endproperty
  a_good_sequence: assert property (p_good_sequence) else $error("good sequence misjudged");

  property p_premature;
    @(posedge ref_clk) disable iff (!rst_n)
      early_now |=> premature_answer_flag && failed_sequence_indicator && sequence_end;
  endproperty
  a_premature: assert property (p_premature) else $error("premature answer not flagged");

  property p_latched;
    @(posedge ref_clk) disable iff (!rst_n)
      sequence_error_flag && !clear_sequence_error |=> sequence_error_flag;
  endproperty
  a_latched: assert property (p_latched) else $error("flag dropped without clear");

endmodule // qawsj_judge

// >>> verification/qawsj_host_model.sv
// host model that writes answer bytes to the sequence judge
`timescale 1ns/1ns
module qawsj_host_model (
  // clock
  input wire logic ref_clk,
  // answer write toward the judge
  output logic answer_write,
  output logic [7:0] answer_byte_port,
  // reference byte shown alongside each write
  output logic [7:0] ref_byte
);
  // idle lines at time zero
  initial begin
    answer_write = 1'b0;
    answer_byte_port = 8'h00;
    ref_byte = 8'h00;
  end
  // back-to-back writes of answers first..first+cnt-1; bad marks corrupted ones
  task automatic burst(input int first, input int cnt, input logic [3:0] bad,
                       input logic [31:0] refs);
    int k;
    for (int i = 0; i < cnt; i++) begin
      @(posedge ref_clk);
      k = first + i;
      answer_write <= 1'b1;
      ref_byte <= refs[8*k +: 8];
      answer_byte_port <= refs[8*k +: 8] ^ (bad[k] ? 8'h5a : 8'h00);
    end
    // released data line does not keep its last value
    if (cnt > 0) begin
      @(posedge ref_clk);
      answer_write <= 1'b0;
      answer_byte_port <= ~answer_byte_port;
      ref_byte <= ~ref_byte;
    end
  endtask
endmodule // qawsj_host_model

// >>> verification/tb.sv
// self-checking testbench for the sequence judge
`timescale 1ns/1ns
module tb;
  logic ref_clk;
  logic rst_n;
  logic wd_enable;
  logic [15:0] win1_len;
  logic [15:0] win2_len;
  logic answer_write;
  logic [7:0] answer_byte_port;
  logic [7:0] expected_answer;
  logic clr; // one strobe for all four clears
  logic wrong_answer_flag;
  logic premature_answer_flag;
  logic sequence_error_flag;
  logic timeout_flag;
  logic failed_sequence_indicator;
  logic [1:0] pending_answer_index;
  logic window2_active;
  logic [2:0] failure_tally;
  logic sequence_end;
  logic question_advance;
  int n_fail;
  int tests_run;
  logic [16:0] lfsr; // random source
  logic [2:0] tally_m; // expected tally
  qawsj_judge #(.CNT_W(16)) qawsj_judge_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .wd_enable(wd_enable), .win1_len(win1_len), .win2_len(win2_len),
    .answer_write(answer_write), .answer_byte_port(answer_byte_port),
    .expected_answer(expected_answer), .clear_wrong_answer(clr),
    .clear_premature_answer(clr), .clear_sequence_error(clr), .clear_timeout(clr),
    .wrong_answer_flag(wrong_answer_flag), .premature_answer_flag(premature_answer_flag),
    .sequence_error_flag(sequence_error_flag), .timeout_flag(timeout_flag),
    .failed_sequence_indicator(failed_sequence_indicator),
    .pending_answer_index(pending_answer_index), .window2_active(window2_active),
    .failure_tally(failure_tally), .sequence_end(sequence_end),
    .question_advance(question_advance));
  qawsj_host_model qawsj_host_model_i (.ref_clk(ref_clk), .answer_write(answer_write),
    .answer_byte_port(answer_byte_port), .ref_byte(expected_answer));
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // next random state
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // expected {wrong, premature, sequence error, timeout, good}
  function automatic logic [4:0] expect_out(input int n1, input int n2, input logic [3:0] bad);
    logic [3:0] used;
    used = 4'((5'h01 << (n1 + n2)) - 5'h01);
    return {|(bad & used), n1 == 4, n1 < 3, n1 + n2 < 4, n1 == 3 && n2 == 1 && !(|bad)};
  endfunction
  // compare the four status flags
  task automatic cmp_flags(input logic [3:0] exp);
    tests_run++;
    if ({wrong_answer_flag, premature_answer_flag, sequence_error_flag, timeout_flag} !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time,
        {wrong_answer_flag, premature_answer_flag, sequence_error_flag, timeout_flag}, exp);
    end
  endtask
  // compare a small number
  task automatic cmp_num(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bounded wait for window two (sel 0) or sequence end (sel 1)
  task automatic wait_high(input int sel);
    int i;
    for (i = 0; i < 300; i++) begin
      #1;
      if ((sel == 0 ? window2_active : sequence_end) === 1'b1) break;
      @(posedge ref_clk);
    end
    if (i == 300) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, i, sel);
      final_report();
    end
  endtask
  // one sequence: clear flags, n1 answers in window one, n2 in window two
  task automatic run_seq(input int n1, input int n2, input logic [3:0] bad);
    logic [4:0] exp;
    logic [31:0] refs;
    exp = expect_out(n1, n2, bad);
    refs = {lfsr[7:0], lfsr[15:8], lfsr[8:1], lfsr[16:9]};
    lfsr = lfsr_next(lfsr);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    #1;
    cmp_flags(4'h0);
    qawsj_host_model_i.burst(0, n1, bad, refs);
    if (n1 < 4) begin
      wait_high(0);
      qawsj_host_model_i.burst(n1, n2, bad, refs);
    end
    wait_high(1);
    cmp_flags(exp[4:1]);
    cmp_num({question_advance, failed_sequence_indicator, 1'b0}, {exp[0], !exp[0], 1'b0});
    cmp_num({1'b0, pending_answer_index}, 3'h3);
    if (exp[0]) tally_m = (tally_m == 3'h0) ? 3'h0 : tally_m - 3'h1;
    else tally_m = (tally_m == 3'h7) ? 3'h7 : tally_m + 3'h1;
    cmp_num(failure_tally, tally_m);
    $display("sequence %0d+%0d bad %h done", n1, n2, bad);
  endtask
  // main sequence
  initial begin
    int n1;
    int n2;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    wd_enable = 1'b0;
    win1_len = 16'h0010;
    win2_len = 16'h0010;
    clr = 1'b0;
    n_fail = 0;
    tests_run = 0;
    lfsr = 17'h17204;
    tally_m = 3'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    cmp_flags(4'h0);
    cmp_num(failure_tally, 3'h0);
    // a write while disabled is ignored
    qawsj_host_model_i.burst(0, 1, 4'h0, 32'h0);
    #1;
    cmp_num({1'b0, pending_answer_index}, 3'h3);
    @(posedge ref_clk);
    wd_enable <= 1'b1;
    run_seq(3, 1, 4'h0);
    run_seq(0, 0, 4'h0);
    run_seq(0, 4, 4'h0);
    run_seq(1, 3, 4'he);
    run_seq(2, 1, 4'h0);
    run_seq(1, 1, 4'h2);
    run_seq(4, 0, 4'h0);
    run_seq(3, 1, 4'h8);
    // random mix of sequences
    for (int r = 0; r < 24; r++) begin
      lfsr = lfsr_next(lfsr);
      n1 = int'(lfsr[2:0]) % 5;
      n2 = int'(lfsr[5:3]) % (5 - n1);
      if (lfsr[14]) run_seq(3, 1, 4'h0);
      else run_seq(n1, n2, lfsr[9:6] & lfsr[13:10]);
    end
    final_report();
  end
endmodule // tb
